// [src/ipm_pkg.sv]
// constants and types shared by the imu power-mode controller
package ipm_pkg;

  // timing, as printed, and derived clock counts
  localparam int CLK_PERIOD_NS     = 5;
  localparam int PWRUP_TIME_US     = 10000;
  localparam int GYR_START_TIME_US = 10000;
  localparam int TIME_TICK_NS      = 39000;
  localparam int ACC_SAMPLE_HZ     = 1600;
  localparam int GYR_SAMPLE_HZ     = 6400;
  localparam int PWRUP_CYCLES      = PWRUP_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int GYR_START_CYCLES  = GYR_START_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIME_TICK_CYCLES  = TIME_TICK_NS / CLK_PERIOD_NS;
  localparam int ACC_TICK_CYCLES   = 1000000000 / (ACC_SAMPLE_HZ * CLK_PERIOD_NS);
  localparam int GYR_TICK_CYCLES   = 1000000000 / (GYR_SAMPLE_HZ * CLK_PERIOD_NS);
  // analogue settling before the first averaged sample, in 1600 Hz ticks
  localparam logic [7:0] ACC_SETTLE_TICKS = 8'h01;

  // register offsets
  localparam logic [7:0] ADDR_STATUS    = 8'h03;
  localparam logic [7:0] ADDR_GYR_L     = 8'h0c;
  localparam logic [7:0] ADDR_GYR_H     = 8'h0d;
  localparam logic [7:0] ADDR_ACC_L     = 8'h12;
  localparam logic [7:0] ADDR_ACC_H     = 8'h13;
  localparam logic [7:0] ADDR_TIME_0    = 8'h18;
  localparam logic [7:0] ADDR_TIME_1    = 8'h19;
  localparam logic [7:0] ADDR_TIME_2    = 8'h1a;
  localparam logic [7:0] ADDR_STAMP_0   = 8'h1c;
  localparam logic [7:0] ADDR_STAMP_1   = 8'h1d;
  localparam logic [7:0] ADDR_STAMP_2   = 8'h1e;
  localparam logic [7:0] ADDR_FIFO_PORT = 8'h24;
  localparam logic [7:0] ADDR_ACC_CFG   = 8'h40;
  localparam logic [7:0] ADDR_GYR_CFG   = 8'h42;
  localparam logic [7:0] ADDR_FIFO_DEC  = 8'h45;
  localparam logic [7:0] ADDR_MODE_CMD  = 8'h7e;

  // reset values
  localparam logic [7:0] ACC_CFG_RST  = 8'h03;
  localparam logic [7:0] GYR_CFG_RST  = 8'h03;
  localparam logic [7:0] FIFO_DEC_RST = 8'h00;

  // field layout of the config, command and status bytes
  localparam int ODR_LSB     = 0;
  localparam int AVG_LSB     = 4;
  localparam int US_BIT      = 7;
  localparam int DEC_ACC_LSB = 0;
  localparam int DEC_GYR_LSB = 4;
  localparam int REQ_ACC_LSB = 0;
  localparam int REQ_GYR_LSB = 4;
  localparam int ST_ACC_LSB  = 0;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_FIFO_BIT = 3;
  localparam int ST_GYR_LSB  = 4;
  localparam int ST_WAKE_BIT = 6;
  localparam int ST_RDY_BIT  = 7;

  // mode codes in the command and status bytes
  localparam logic [1:0] ACC_CODE_SUSP = 2'h0;
  localparam logic [1:0] ACC_CODE_NORM = 2'h1;
  localparam logic [1:0] ACC_CODE_LP   = 2'h2;
  localparam logic [1:0] GYR_CODE_SUSP = 2'h0;
  localparam logic [1:0] GYR_CODE_NORM = 2'h1;
  localparam logic [1:0] GYR_CODE_FSU  = 2'h3;

  typedef enum logic [2:0] {
    ACC_SUSP = 3'b001,
    ACC_NORM = 3'b010,
    ACC_LP   = 3'b100
  } ipm_acc_mode_e;

  typedef enum logic [3:0] {
    GYR_SUSP  = 4'b0001,
    GYR_FSU   = 4'b0010,
    GYR_START = 4'b0100,
    GYR_NORM  = 4'b1000
  } ipm_gyr_mode_e;

  typedef struct packed {
    logic        acc_valid;
    logic        gyr_valid;
    logic [15:0] acc_sample;
    logic [15:0] gyr_sample;
    logic [23:0] stamp;
  } ipm_frame_s;

endpackage

// [src/ipm_power_ctrl.sv]
// power-mode control, filtering and frame decimation of the imu core
// Notes on behaviour
// - after reset both sensors sit in suspend until the host asks otherwise
// - power-up completes and ready rises within 10 ms
// - raw accel sampled at 1600 Hz, raw gyro at 6400 Hz, whatever the output rate
// - each stream averaged and decimated to the rate in its config byte
// - frames to fifo are further decimated by dropping whole frames
// - time stamp captured in the same cycle as each data update
// - accel low power duty-cycles; fifo readable only while awake
// - suspend takes no samples, keeps data and refuses fifo reads
// - suspend powers off sensing but register access stays live
// - gyro fast start-up keeps data and config, normal within 10 ms
// - only listed mode pairs; accel low power needs gyro suspended
// - one sensor's mode changes per step; host asks single moves only
// - normal to low power switching leaves output data untouched
// - mode requests accepted whatever the configured output rate
// - low power stays awake when sleep gap is too short
// - undersampling makes normal mode mimic low power averaging
// - each low power wake lasts settling plus averaged samples
// - undersampling bit set to one enables averaging-limited sampling
`timescale 1ns/1ps
module ipm_power_ctrl #(
  parameter int P_PWRUP_CYCLES     = ipm_pkg::PWRUP_CYCLES,
  parameter int P_GYR_START_CYCLES = ipm_pkg::GYR_START_CYCLES,
  parameter int P_TIME_TICK_CYCLES = ipm_pkg::TIME_TICK_CYCLES,
  parameter int P_ACC_TICK_CYCLES  = ipm_pkg::ACC_TICK_CYCLES,
  parameter int P_GYR_TICK_CYCLES  = ipm_pkg::GYR_TICK_CYCLES
) (
  input  wire logic                MCLK_I,
  input  wire logic                RST_I,
  input  wire logic [7:0]          REG_ADDR_I,
  input  wire logic [7:0]          REG_WDATA_I,
  input  wire logic                REG_WR_I,
  input  wire logic                REG_RD_I,
  output      logic [7:0]          REG_RDATA_O,
  input  wire logic [15:0]         ACC_SAMPLE_I,
  input  wire logic [15:0]         GYR_SAMPLE_I,
  input  wire logic [7:0]          FIFO_BYTE_I,
  output      logic                FIFO_POP_O,
  output      logic                FIFO_WR_O,
  output      ipm_pkg::ipm_frame_s FIFO_FRAME_O,
  output      logic                ACC_PWR_O,
  output      logic                GYR_PWR_O,
  output      logic                GYR_DRIVE_O,
  output      logic                READY_O
);
  import ipm_pkg::*;

  typedef struct packed {
    ipm_acc_mode_e      acc_mode;
    ipm_gyr_mode_e      gyr_mode;
    logic [1:0]         gyr_code;
    logic               ready;
    logic [23:0]        pwr_cnt;
    logic [23:0]        gyr_cnt;
    logic [23:0]        acc_tick_cnt;
    logic [23:0]        gyr_tick_cnt;
    logic [23:0]        time_tick_cnt;
    logic [23:0]        sensor_time;
    logic [23:0]        data_stamp;
    logic [7:0]         acc_cfg;
    logic [7:0]         gyr_cfg;
    logic [7:0]         fifo_dec;
    logic [7:0]         acc_idx;
    logic [7:0]         gyr_idx;
    logic signed [23:0] acc_sum;
    logic signed [23:0] gyr_sum;
    logic [15:0]        acc_data;
    logic [15:0]        gyr_data;
    logic [7:0]         acc_frame;
    logic [7:0]         gyr_frame;
    logic               acc_awake;
    logic               fifo_wr;
    ipm_frame_s         frame;
    logic [7:0]         rdata;
  } ipm_state_s;

  ipm_state_s         st;
  ipm_state_s         n;

  logic               acc_tick;
  logic               gyr_tick;
  logic               time_tick;
  logic               acc_on;
  logic               acc_lp;
  logic [2:0]         acc_shift;
  logic [2:0]         acc_avg;
  logic [2:0]         used_exp;
  logic [7:0]         used;
  logic [7:0]         acc_last;
  logic [8:0]         win_end;
  logic               duty_ok;
  logic [7:0]         offset;
  logic               in_window;
  logic               awake;
  logic signed [23:0] acc_sum_in;
  logic signed [23:0] gyr_sum_in;
  logic [2:0]         gyr_shift;
  logic [7:0]         gyr_last;
  logic               acc_upd;
  logic               gyr_upd;
  logic [7:0]         acc_flast;
  logic [7:0]         gyr_flast;
  logic               fifo_ok;
  logic [1:0]         acc_code;
  logic [7:0]         status;
  logic               req_ok;
  ipm_acc_mode_e      tgt_acc;
  ipm_gyr_mode_e      tgt_gyr;

  always_comb begin
    n = st;
    n.fifo_wr = 1'b0;
    n.frame.acc_valid = 1'b0;
    n.frame.gyr_valid = 1'b0;

    if (!st.ready) begin
      if (st.pwr_cnt >= 24'(P_PWRUP_CYCLES - 1)) begin
        n.ready = 1'b1;
      end else begin
        n.pwr_cnt = st.pwr_cnt + 24'h000001;
      end
    end

    // fixed raw sample ticks, free running in every mode
    acc_tick = (st.acc_tick_cnt == 24'(P_ACC_TICK_CYCLES - 1));
    gyr_tick = (st.gyr_tick_cnt == 24'(P_GYR_TICK_CYCLES - 1));
    time_tick = (st.time_tick_cnt == 24'(P_TIME_TICK_CYCLES - 1));
    n.acc_tick_cnt = acc_tick ? '0 : st.acc_tick_cnt + 24'h000001;
    n.gyr_tick_cnt = gyr_tick ? '0 : st.gyr_tick_cnt + 24'h000001;
    n.time_tick_cnt = time_tick ? '0 : st.time_tick_cnt + 24'h000001;
    n.sensor_time = time_tick ? st.sensor_time + 24'h000001 : st.sensor_time;

    // accel window arithmetic; the rate field is decoupled from the mode
    acc_on = (st.acc_mode != ACC_SUSP);
    acc_lp = (st.acc_mode == ACC_LP);
    acc_shift = st.acc_cfg[ODR_LSB +: 3];
    acc_avg = st.acc_cfg[AVG_LSB +: 3];
    acc_last = (8'h01 << acc_shift) - 8'h01;
    // undersampling limits the averaged samples per period
    // enabled by the undersample bit, always in low power
    if ((st.acc_cfg[US_BIT] || acc_lp) && (acc_avg < acc_shift)) begin
      used_exp = acc_avg;
    end else begin
      used_exp = acc_shift;
    end
    used = 8'h01 << used_exp;
    // wake spans settling plus the averaged samples
    win_end = {1'b0, ACC_SETTLE_TICKS} + {1'b0, used};
    // gap too short means staying awake for good
    duty_ok = (win_end < ({1'b0, acc_last} + 9'h001));
    offset = (acc_lp && duty_ok) ? ACC_SETTLE_TICKS : 8'h00;
    in_window = (st.acc_idx >= offset) &&
                ({1'b0, st.acc_idx} < ({1'b0, offset} + {1'b0, used}));
    // low power alternates between awake and suspended
    awake = (st.acc_mode == ACC_NORM) ||
            (acc_lp && (!duty_ok || ({1'b0, st.acc_idx} < win_end)));
    n.acc_awake = awake;

    acc_upd = 1'b0;
    acc_sum_in = st.acc_sum;
    if (awake && in_window) begin
      acc_sum_in = st.acc_sum + {{8{ACC_SAMPLE_I[15]}}, ACC_SAMPLE_I};
    end
    // suspend takes nothing and keeps the last data
    if (acc_tick && acc_on) begin
      if (st.acc_idx >= acc_last) begin
        n.acc_data = 16'(acc_sum_in >>> used_exp);
        n.acc_sum = '0;
        n.acc_idx = '0;
        acc_upd = 1'b1;
      end else begin
        n.acc_sum = acc_sum_in;
        n.acc_idx = st.acc_idx + 8'h01;
      end
    end

    // gyro samples only in normal, data kept otherwise
    gyr_upd = 1'b0;
    gyr_shift = st.gyr_cfg[ODR_LSB +: 3];
    gyr_last = (8'h01 << gyr_shift) - 8'h01;
    gyr_sum_in = st.gyr_sum + {{8{GYR_SAMPLE_I[15]}}, GYR_SAMPLE_I};
    if (gyr_tick && (st.gyr_mode == GYR_NORM)) begin
      if (st.gyr_idx >= gyr_last) begin
        n.gyr_data = 16'(gyr_sum_in >>> gyr_shift);
        n.gyr_sum = '0;
        n.gyr_idx = '0;
        gyr_upd = 1'b1;
      end else begin
        n.gyr_sum = gyr_sum_in;
        n.gyr_idx = st.gyr_idx + 8'h01;
      end
    end

    // stamp moves with the data registers
    if (acc_upd || gyr_upd) begin
      n.data_stamp = st.sensor_time;
      n.frame.stamp = st.sensor_time;
    end

    // drop whole frames on the way to the fifo
    acc_flast = (8'h01 << st.fifo_dec[DEC_ACC_LSB +: 3]) - 8'h01;
    gyr_flast = (8'h01 << st.fifo_dec[DEC_GYR_LSB +: 3]) - 8'h01;
    if (acc_upd) begin
      if (st.acc_frame >= acc_flast) begin
        n.acc_frame = '0;
        n.frame.acc_valid = 1'b1;
        n.frame.acc_sample = n.acc_data;
        n.fifo_wr = 1'b1;
      end else begin
        n.acc_frame = st.acc_frame + 8'h01;
      end
    end
    if (gyr_upd) begin
      if (st.gyr_frame >= gyr_flast) begin
        n.gyr_frame = '0;
        n.frame.gyr_valid = 1'b1;
        n.frame.gyr_sample = n.gyr_data;
        n.fifo_wr = 1'b1;
      end else begin
        n.gyr_frame = st.gyr_frame + 8'h01;
      end
    end

    // gyro start-up to normal, bounded count
    unique case (st.gyr_mode)
      GYR_START: begin
        if (st.gyr_cnt >= 24'(P_GYR_START_CYCLES - 1)) begin
          n.gyr_mode = GYR_NORM;
          // code changes only once normal is reached
          n.gyr_code = GYR_CODE_NORM;
        end else begin
          n.gyr_cnt = st.gyr_cnt + 24'h000001;
        end
      end
      GYR_SUSP, GYR_FSU, GYR_NORM: begin
        n.gyr_cnt = '0;
      end
    endcase

    // decode of a mode request
    req_ok = 1'b1;
    case (REG_WDATA_I[REQ_ACC_LSB +: 2])
      ACC_CODE_SUSP: tgt_acc = ACC_SUSP;
      ACC_CODE_NORM: tgt_acc = ACC_NORM;
      ACC_CODE_LP:   tgt_acc = ACC_LP;
      default: begin
        tgt_acc = st.acc_mode;
        req_ok = 1'b0;
      end
    endcase
    case (REG_WDATA_I[REQ_GYR_LSB +: 2])
      GYR_CODE_SUSP: tgt_gyr = GYR_SUSP;
      GYR_CODE_NORM: tgt_gyr = GYR_NORM;
      GYR_CODE_FSU:  tgt_gyr = GYR_FSU;
      default: begin
        tgt_gyr = st.gyr_mode;
        req_ok = 1'b0;
      end
    endcase
    // exactly one sensor may move per request
    if ((tgt_acc != st.acc_mode) == (tgt_gyr != st.gyr_mode)) begin
      req_ok = 1'b0;
    end
    // low power only beside a suspended gyro
    if ((tgt_acc == ACC_LP) && (tgt_gyr != GYR_SUSP)) begin
      req_ok = 1'b0;
    end
    // refused while starting up or before ready
    if ((st.gyr_mode == GYR_START) || !st.ready) begin
      req_ok = 1'b0;
    end

    // registers stay reachable in every mode once ready
    if (REG_WR_I && st.ready) begin
      case (REG_ADDR_I)
        // rate settings independent of the mode
        ADDR_ACC_CFG:  n.acc_cfg = REG_WDATA_I;
        ADDR_GYR_CFG:  n.gyr_cfg = REG_WDATA_I;
        ADDR_FIFO_DEC: n.fifo_dec = REG_WDATA_I;
        ADDR_MODE_CMD: begin
          // accel data and sums untouched by the switch
          if (req_ok && (tgt_acc != st.acc_mode)) begin
            n.acc_mode = tgt_acc;
          end
          if (req_ok && (tgt_gyr != st.gyr_mode)) begin
            if (tgt_gyr == GYR_NORM) begin
              n.gyr_mode = GYR_START;
              n.gyr_cnt = '0;
            end else begin
              n.gyr_mode = tgt_gyr;
              n.gyr_code = REG_WDATA_I[REQ_GYR_LSB +: 2];
            end
          end
        end
        default: ;
      endcase
    end

    // fifo readable in low power only while awake
    fifo_ok = (st.acc_mode == ACC_NORM) || (st.gyr_mode == GYR_NORM) ||
              (acc_lp && st.acc_awake);
    case (st.acc_mode)
      ACC_NORM: acc_code = ACC_CODE_NORM;
      ACC_LP:   acc_code = ACC_CODE_LP;
      default:  acc_code = ACC_CODE_SUSP;
    endcase
    status = '0;
    status[ST_ACC_LSB +: 2] = acc_code;
    status[ST_BUSY_BIT] = (st.gyr_mode == GYR_START);
    status[ST_FIFO_BIT] = fifo_ok;
    status[ST_GYR_LSB +: 2] = st.gyr_code;
    status[ST_WAKE_BIT] = st.acc_awake;
    status[ST_RDY_BIT] = st.ready;

    if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_STATUS:    n.rdata = status;
        ADDR_GYR_L:     n.rdata = st.gyr_data[7:0];
        ADDR_GYR_H:     n.rdata = st.gyr_data[15:8];
        ADDR_ACC_L:     n.rdata = st.acc_data[7:0];
        ADDR_ACC_H:     n.rdata = st.acc_data[15:8];
        ADDR_TIME_0:    n.rdata = st.sensor_time[7:0];
        ADDR_TIME_1:    n.rdata = st.sensor_time[15:8];
        ADDR_TIME_2:    n.rdata = st.sensor_time[23:16];
        ADDR_STAMP_0:   n.rdata = st.data_stamp[7:0];
        ADDR_STAMP_1:   n.rdata = st.data_stamp[15:8];
        ADDR_STAMP_2:   n.rdata = st.data_stamp[23:16];
        // no fifo data while asleep, reads as zero
        ADDR_FIFO_PORT: n.rdata = (fifo_ok && st.ready) ? FIFO_BYTE_I : 8'h00;
        ADDR_ACC_CFG:   n.rdata = st.acc_cfg;
        ADDR_GYR_CFG:   n.rdata = st.gyr_cfg;
        ADDR_FIFO_DEC:  n.rdata = st.fifo_dec;
        default:        n.rdata = 8'h00;
      endcase
    end
  end

  // a popped byte is only taken when the read is honoured
  assign FIFO_POP_O = REG_RD_I && (REG_ADDR_I == ADDR_FIFO_PORT) &&
                      fifo_ok && st.ready;

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      st <= '0;
      st.acc_mode <= ACC_SUSP;
      st.gyr_mode <= GYR_SUSP;
      st.gyr_code <= GYR_CODE_SUSP;
      st.acc_cfg <= ACC_CFG_RST;
      st.gyr_cfg <= GYR_CFG_RST;
      st.fifo_dec <= FIFO_DEC_RST;
    end else begin
      st <= n;
    end
  end

  assign REG_RDATA_O = st.rdata;
  assign FIFO_WR_O = st.fifo_wr;
  assign FIFO_FRAME_O = st.frame;
  // sensing power follows the awake phase, a cycle behind
  assign ACC_PWR_O = st.acc_awake;
  assign GYR_PWR_O = (st.gyr_mode == GYR_START) || (st.gyr_mode == GYR_NORM);
  assign GYR_DRIVE_O = (st.gyr_mode != GYR_SUSP);
  assign READY_O = st.ready;

endmodule

// [dv/ipm_power_ctrl_checker.sv]
// port-level assertions for the imu power-mode controller
`timescale 1ns/1ps
module ipm_power_ctrl_checker
  import ipm_pkg::*;
#(
  parameter int P_PWRUP_CYCLES = 20
) (
  input wire logic                MCLK_I,
  input wire logic                RST_I,
  input wire logic [7:0]          REG_ADDR_I,
  input wire logic                REG_RD_I,
  input wire logic [7:0]          REG_RDATA_O,
  input wire logic                FIFO_POP_O,
  input wire logic                FIFO_WR_O,
  input wire ipm_pkg::ipm_frame_s FIFO_FRAME_O,
  input wire logic                ACC_PWR_O,
  input wire logic                GYR_PWR_O,
  input wire logic                GYR_DRIVE_O,
  input wire logic                READY_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  // cycles spent waiting for ready since the last reset
  int wait_cnt;
  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) wait_cnt <= 0;
    else if (!READY_O) wait_cnt <= wait_cnt + 1;
  end

  sequence fifo_read_s;
    REG_RD_I && REG_ADDR_I == ADDR_FIFO_PORT;
  endsequence

  chk_pop_on_read: assert property (
    FIFO_POP_O |-> fifo_read_s) else $error("pop without fifo read");
  chk_pop_ready: assert property (
    FIFO_POP_O |-> READY_O) else $error("pop before ready");
  chk_ready_holds: assert property (
    READY_O |=> READY_O) else $error("ready dropped");
  chk_pwrup_bound: assert property (
    !READY_O |-> wait_cnt <= P_PWRUP_CYCLES) else $error("ready late");
  chk_gyr_drive: assert property (
    GYR_PWR_O |-> GYR_DRIVE_O) else $error("gyro sensing without drive");
  chk_asleep_unready: assert property (
    !READY_O |-> !ACC_PWR_O && !GYR_DRIVE_O) else $error("awake at power-up");
  chk_frame_pulse: assert property (
    (FIFO_FRAME_O.acc_valid || FIFO_FRAME_O.gyr_valid) == FIFO_WR_O)
    else $error("frame valid bits disagree with write pulse");
  chk_gyr_frame_on: assert property (
    FIFO_FRAME_O.gyr_valid |-> $past(GYR_PWR_O))
    else $error("gyro frame while gyro off");
  chk_rdata_hold: assert property (
    !$past(REG_RD_I) |-> $stable(REG_RDATA_O))
    else $error("read data moved without read");
endmodule

bind ipm_power_ctrl ipm_power_ctrl_checker #(
  .P_PWRUP_CYCLES(P_PWRUP_CYCLES)
) u_chk (
  .MCLK_I, .RST_I, .REG_ADDR_I, .REG_RD_I, .REG_RDATA_O, .FIFO_POP_O,
  .FIFO_WR_O, .FIFO_FRAME_O, .ACC_PWR_O, .GYR_PWR_O, .GYR_DRIVE_O, .READY_O
);

// [dv/ipm_host_model.sv]
// host processor model driving the register port
`timescale 1ns/1ps
module ipm_host_model #(
  parameter int WR_GAP = 2
) (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       pop_i,
  output      logic [7:0] addr_o,
  output      logic [7:0] wdata_o,
  output      logic       wr_o,
  output      logic       rd_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // single writes only, then a pause (gap shortened for sim)
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    repeat (WR_GAP) @(negedge clk_i);
  endtask

  // pop is combinational, so it is caught while the strobe is up
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic p);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    #1 p = pop_i;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// [dv/ipm_power_ctrl_bench.sv]
// self-checking bench for the imu power-mode controller
`timescale 1ns/1ps
module ipm_power_ctrl_bench;
  import ipm_pkg::*;
  localparam int GS = 10;
  logic       mclk, rst, wr, rd, pop, fwr, apwr, gpwr, gdrv, rdy, p;
  logic [7:0] addr, wdata, rdata, fbyte, d, cfg;
  logic [15:0] acc_s, gyr_s, old_s;
  ipm_frame_s frame;
  int         error_cnt = 0;
  int         comparisons = 0;
  int         m_acc = 0;
  int         m_gyr = 0;
  int         n;
  int         na_t[14] = '{1, 0, 2, 2, 3, 1, 1, 2, 1, 1, 1, 1, 0, 1};
  int         ng_t[14] = '{0, 1, 0, 1, 0, 0, 1, 1, 3, 1, 2, 0, 0, 1};
  logic [7:0] ra[3] = '{ADDR_ACC_CFG, ADDR_GYR_CFG, ADDR_FIFO_DEC};
  logic [7:0] rv[3] = '{ACC_CFG_RST, GYR_CFG_RST, FIFO_DEC_RST};

  ipm_power_ctrl #(
    .P_PWRUP_CYCLES(20), .P_GYR_START_CYCLES(GS), .P_TIME_TICK_CYCLES(8),
    .P_ACC_TICK_CYCLES(16), .P_GYR_TICK_CYCLES(4)
  ) dut (
    .MCLK_I(mclk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .ACC_SAMPLE_I(acc_s), .GYR_SAMPLE_I(gyr_s), .FIFO_BYTE_I(fbyte),
    .FIFO_POP_O(pop), .FIFO_WR_O(fwr), .FIFO_FRAME_O(frame),
    .ACC_PWR_O(apwr), .GYR_PWR_O(gpwr), .GYR_DRIVE_O(gdrv), .READY_O(rdy)
  );
  ipm_host_model #(.WR_GAP(2)) host (
    .clk_i(mclk), .rdata_i(rdata), .pop_i(pop), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd)
  );

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // waits for a fresh accel frame; a missed one counts as a mismatch
  task automatic wait_acc;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (!(fwr === 1'b1 && frame.acc_valid === 1'b1) && n < 64);
    check(16'(n < 64), 16'h1);
  endtask

  task automatic count_wr(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (fwr === 1'b1) c++;
    end
  endtask

  // mode model: one field moves, codes valid, low power only w/o gyro
  task automatic cmd(input int na, input int ng);
    bit ok;
    ok = na != 3 && ng != 2 && ((na != m_acc) ^ (ng != m_gyr))
         && !(na == 2 && ng != 0);
    host.wr_reg(ADDR_MODE_CMD, {2'b00, 2'(ng), 2'b00, 2'(na)});
    if (ok && ng == 1 && m_gyr != 1) begin
      host.rd_reg(ADDR_STATUS, d, p);
      check(16'(d[ST_BUSY_BIT]), 16'h1);
      repeat (GS) @(negedge mclk);
    end
    if (ok) begin
      m_acc = na;
      m_gyr = ng;
    end
    host.rd_reg(ADDR_STATUS, d, p);
    check(16'(d & 8'hb3), 16'(8'h80 | (m_gyr << 4) | m_acc));
    check(16'({gpwr, gdrv}), 16'({m_gyr == 1, m_gyr != 0}));
    // low power toggles the accel supply, so only steady modes are checked
    if (m_acc != 2) begin
      check(16'(apwr), 16'(m_acc == 1));
    end
  endtask

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    n = $urandom(32'h946b);
    acc_s = 16'($urandom);
    gyr_s = 16'($urandom);
    fbyte = 8'($urandom);
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      host.rd_reg(ra[i], d, p);
      check(16'(d), 16'(rv[i]));
    end
    host.rd_reg(ADDR_STATUS, d, p);
    check(16'(d), 16'h0000);
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    check(16'(rdy), 16'h1);
    cfg = 8'($urandom) & 8'hf7;
    host.wr_reg(ADDR_ACC_CFG, cfg);
    host.rd_reg(ADDR_ACC_CFG, d, p);
    check(16'(d), 16'(cfg));
    host.rd_reg(8'h50, d, p);
    check(16'(d), 16'h0000);
    // the odr just set is arbitrary, mode moves must not care
    for (int i = 0; i < 14; i++) begin
      cmd(na_t[i], ng_t[i]);
    end
    host.rd_reg(ADDR_FIFO_PORT, d, p);
    check({p, 7'h00, d}, 16'h0000);
    cmd(1, 0);
    host.rd_reg(ADDR_FIFO_PORT, d, p);
    check({p, 7'h00, d}, {8'h80, fbyte});
    host.wr_reg(ADDR_ACC_CFG, 8'h00);
    // the first frame may still carry a sum begun under the old rate
    wait_acc();
    wait_acc();
    // constant input, so any average equals the raw sample
    check(frame.acc_sample, acc_s);
    host.rd_reg(ADDR_STAMP_0, d, p);
    check(16'(d), 16'(frame.stamp[7:0]));
    host.rd_reg(ADDR_ACC_H, d, p);
    check(16'(d), 16'(acc_s[15:8]));
    host.wr_reg(ADDR_FIFO_DEC, 8'h01);
    count_wr(128, n);
    check(16'(n), 16'd4);
    cmd(0, 0);
    old_s = acc_s;
    acc_s = ~acc_s;
    count_wr(64, n);
    check(16'(n), 16'd0);
    host.rd_reg(ADDR_ACC_L, d, p);
    check(16'(d), 16'(old_s[7:0]));
    close_out();
  end
endmodule
